// ---- core/cfm_device.sv ----
// controller end: mode state machine, length decode, config write guard
// assumes a protocol engine on the same clock and a bus pin from outside
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`include "cfm_params.svh"

module cfm_device #(
    parameter int INTEG_BITS = `CFM_INTEG_BITS,
    parameter int WAKE_FILT_CYC = `CFM_WAKE_FILT_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    cfm_if.device host,
    input wire logic bus_rx_pin,
    output logic bus_tx_pin,
    input wire logic bit_tick,
    input wire logic tx_bit,
    input wire logic tx_busy,
    input wire logic rx_busy,
    input wire logic tx_err,
    input wire logic rx_err,
    input wire logic tx_fdf,
    input wire logic tx_brs,
    input wire logic tx_esi,
    output logic tx_fdf_out,
    output logic tx_brs_out,
    output logic tx_esi_out,
    input wire logic rx_fdf,
    output logic rx_fd_error,
    input wire cfm_pkg::cfm_dlc_t dlc,
    input wire logic dlc_fd,
    output cfm_pkg::cfm_bytes_t byte_count,
    output logic crc21,
    output logic clock_stop
);
    import cfm_pkg::*;

    if (INTEG_BITS < 1 || INTEG_BITS > 255 || WAKE_FILT_CYC < 1 || WAKE_FILT_CYC > 255) begin : g_chk
        $error("cfm_device: counts out of range");
    end

    localparam logic [7:0] INTEG_LAST = 8'(INTEG_BITS - 1);
    localparam logic [7:0] FILT_LAST = 8'(WAKE_FILT_CYC - 1);

    cfm_state_t state;
    cfm_state_t next_state;
    cfm_op_t run_op;
    cfm_op_t pend_op;
    logic pend_valid;
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    logic [7:0] integ_cnt;
    logic [7:0] filt_cnt;
    logic wake_evt;
    logic lpm_rst;
    logic soft_rst;
    logic bus_idle;
    logic leave_cfg;

    function automatic cfm_bytes_t dlc_bytes(input cfm_dlc_t d, input logic fd);
        if (d <= 4'h8)
            return cfm_bytes_t'(d);
        else if (!fd)
            return 7'h08;
        case (d)
            4'h9: return 7'h0C;
            4'hA: return 7'h10;
            4'hB: return 7'h14;
            4'hC: return 7'h18;
            4'hD: return 7'h20;
            4'hE: return 7'h30;
            default: return 7'h40;
        endcase
    endfunction

    function automatic logic is_normal(input cfm_op_t op);
        return op == `CFM_OP_NORMAL_FD || op == `CFM_OP_CLASSIC;
    endfunction

    function automatic logic is_debug(input cfm_op_t op);
        return op == `CFM_OP_LISTEN || op == `CFM_OP_RESTRICT ||
               op == `CFM_OP_LOOP_INT || op == `CFM_OP_LOOP_EXT;
    endfunction

    // from a running mode only config, the same mode, or sleep from a normal mode may follow
    function automatic logic legal(input cfm_state_t s, input cfm_op_t cur, input cfm_op_t op);
        if (s == CFM_CFG)
            return 1'b1;
        if (s == CFM_RUN)
            return op == `CFM_OP_CONFIG || op == cur ||
                   (op == `CFM_OP_SLEEP && is_normal(cur));
        return 1'b0;
    endfunction

    // tx and rx busy cover a frame in flight, so no change out of config or a running mode cuts it
    assign bus_idle = !tx_busy && !rx_busy;
    assign soft_rst = reset || lpm_rst;
    assign leave_cfg = state == CFM_CFG && next_state != CFM_CFG;

    // pin from outside the clock domain
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_prev <= 1'b1;
        end else if (ce) begin
            rx_s1 <= bus_rx_pin;
            rx_s2 <= rx_s1;
            rx_prev <= rx_s2;
        end
    end

    // wake on a falling edge, or after a low of the filter time when filtered
    always_ff @(posedge clk) begin
        if (soft_rst) begin
            filt_cnt <= 8'h00;
        end else if (ce) begin
            if (rx_s2 || (state != CFM_SLEEP && state != CFM_LPM))
                filt_cnt <= 8'h00;
            else if (filt_cnt != 8'hFF)
                filt_cnt <= filt_cnt + 8'h01;
        end
    end

    always_comb begin
        if (state != CFM_SLEEP && state != CFM_LPM)
            wake_evt = 1'b0;
        else if (host.wake_filter_enable)
            wake_evt = filt_cnt == FILT_LAST;
        else
            wake_evt = rx_prev && !rx_s2;
    end

    // pending request, dropped when illegal
    always_ff @(posedge clk) begin
        if (soft_rst) begin
            pend_valid <= 1'b0;
            pend_op <= `CFM_OP_CONFIG;
        end else if (ce) begin
            if (host.req_stb && legal(state, run_op, host.requested_op_field)) begin
                pend_valid <= 1'b1;
                pend_op <= host.requested_op_field;
            end else if (host.req_stb || next_state != state) begin
                pend_valid <= 1'b0;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            CFM_CFG: begin
                if (pend_valid && bus_idle && pend_op == `CFM_OP_SLEEP)
                    next_state = host.low_power_enable_bit ? CFM_LPM : CFM_SLEEP;
                else if (pend_valid && bus_idle && pend_op != `CFM_OP_CONFIG)
                    next_state = CFM_INTEG;
            end
            CFM_INTEG: begin
                if (pend_valid && pend_op == `CFM_OP_CONFIG)
                    next_state = CFM_CFG;
                else if (bit_tick && rx_s2 && integ_cnt == INTEG_LAST)
                    next_state = CFM_RUN;
            end
            CFM_RUN: begin
                if (pend_valid && bus_idle && pend_op == `CFM_OP_CONFIG)
                    next_state = CFM_CFG;
                else if (pend_valid && bus_idle && pend_op == `CFM_OP_SLEEP)
                    next_state = host.low_power_enable_bit ? CFM_LPM : CFM_SLEEP;
            end
            CFM_SLEEP: begin
                if (host.osc_clear || wake_evt)
                    next_state = CFM_CFG;
            end
            CFM_LPM: begin
                if (host.cs_assert || wake_evt)
                    next_state = CFM_CFG;
            end
            default: next_state = CFM_CFG;
        endcase
    end

    always_ff @(posedge clk) begin
        if (soft_rst) begin
            state <= CFM_CFG;
            run_op <= `CFM_OP_CONFIG;
        end else if (ce) begin
            state <= next_state;
            if (state == CFM_CFG && next_state == CFM_INTEG)
                run_op <= pend_op;
            else if (next_state != CFM_INTEG && next_state != CFM_RUN)
                run_op <= `CFM_OP_CONFIG;
        end
    end

    // dominant bit restarts the recessive run
    always_ff @(posedge clk) begin
        if (soft_rst) begin
            integ_cnt <= 8'h00;
        end else if (ce) begin
            if (state != CFM_INTEG || (bit_tick && !rx_s2))
                integ_cnt <= 8'h00;
            else if (bit_tick && integ_cnt != INTEG_LAST)
                integ_cnt <= integ_cnt + 8'h01;
        end
    end

    // leaving low power resets the controller-end state, outputs and counters but not the host registers; one pulse is enough
    always_ff @(posedge clk) begin
        if (reset)
            lpm_rst <= 1'b0;
        else if (ce)
            lpm_rst <= state == CFM_LPM && next_state == CFM_CFG;
    end

    always_ff @(posedge clk) begin
        if (soft_rst) begin
            host.current_op_field <= `CFM_OP_CONFIG;
            host.op_change <= 1'b0;
            host.fifo_reset_flag <= 1'b1;
            clock_stop <= 1'b0;
            bus_tx_pin <= 1'b1;
        end else if (ce) begin
            host.current_op_field <= state == CFM_RUN ? run_op : `CFM_OP_CONFIG;
            host.op_change <= host.current_op_field != (state == CFM_RUN ? run_op : `CFM_OP_CONFIG);
            host.fifo_reset_flag <= state == CFM_CFG;
            clock_stop <= state == CFM_SLEEP || state == CFM_LPM;
            bus_tx_pin <= state == CFM_RUN ? tx_bit : 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (soft_rst)
            host.osc_disable_bit <= 1'b0;
        else if (ce) begin
            if (state == CFM_SLEEP && !host.osc_clear)
                host.osc_disable_bit <= 1'b1;
            else if (host.osc_clear || state != CFM_SLEEP)
                host.osc_disable_bit <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (soft_rst)
            host.wake_irq <= 1'b0;
        else if (ce)
            host.wake_irq <= wake_evt && host.wake_irq_enable;
    end

    always_ff @(posedge clk) begin
        if (soft_rst)
            host.cfg_rdata <= 8'h00;
        else if (ce && host.cfg_stb && state == CFM_CFG && host.current_op_field == `CFM_OP_CONFIG)
            host.cfg_rdata <= host.cfg_wdata;
    end

    always_ff @(posedge clk) begin
        if (soft_rst || (ce && leave_cfg)) begin
            host.error_counter_reg <= 8'h00;
            host.bus_diag_reg0 <= 8'h00;
            host.bus_diag_reg1 <= 8'h00;
        end else if (ce && state == CFM_RUN) begin
            host.error_counter_reg <= host.error_counter_reg + 8'({tx_err & rx_err, tx_err ^ rx_err});
            host.bus_diag_reg0 <= host.bus_diag_reg0 + 8'(tx_err);
            host.bus_diag_reg1 <= host.bus_diag_reg1 + 8'(rx_err);
        end
    end

    always_ff @(posedge clk) begin
        if (soft_rst) begin
            tx_fdf_out <= 1'b0;
            tx_brs_out <= 1'b0;
            tx_esi_out <= 1'b0;
            rx_fd_error <= 1'b0;
            byte_count <= 7'h00;
            crc21 <= 1'b0;
        end else if (ce) begin
            tx_fdf_out <= tx_fdf && run_op != `CFM_OP_CLASSIC;
            tx_brs_out <= tx_brs && run_op != `CFM_OP_CLASSIC;
            tx_esi_out <= tx_esi && run_op != `CFM_OP_CLASSIC;
            rx_fd_error <= state == CFM_RUN && run_op == `CFM_OP_CLASSIC && rx_fdf;
            byte_count <= dlc_bytes(dlc, dlc_fd);
            crc21 <= dlc_fd && dlc_bytes(dlc, dlc_fd) > 7'h10;
        end
    end
endmodule

// ---- core/cfm_host.sv ----
// host end: avalon-mm slave registers that drive the controller end
// assumes avalon master on the same clock; controller end on the link
`include "cfm_params.svh"
module cfm_host (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    cfm_if.host dev,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import cfm_pkg::*;

    logic [31:0] ctrl;
    logic changed;
    logic woke;
    logic done;
    logic wr;
    cfm_op_t target;
    logic target_pend;
    logic conflict;

    // every access waits one cycle so read data come from a flop
    assign avs_waitrequest = (avs_read || avs_write) && !done;
    assign wr = avs_write && done && ce;

    function automatic logic same_group_other(input cfm_op_t a, input cfm_op_t b);
        logic na;
        logic nb;
        na = a == `CFM_OP_NORMAL_FD || a == `CFM_OP_CLASSIC;
        nb = b == `CFM_OP_NORMAL_FD || b == `CFM_OP_CLASSIC;
        if (a == b || a == `CFM_OP_CONFIG || a == `CFM_OP_SLEEP)
            return 1'b0;
        if (b == `CFM_OP_CONFIG || b == `CFM_OP_SLEEP)
            return 1'b0;
        return na == nb;
    endfunction

    assign conflict = same_group_other(dev.current_op_field, avs_writedata[2:0]);

    always_ff @(posedge clk) begin
        if (reset)
            done <= 1'b0;
        else if (ce)
            done <= (avs_read || avs_write) && !done;
    end

    always_ff @(posedge clk) begin
        if (reset)
            avs_readdata <= 32'h0000_0000;
        else if (ce && avs_read && !done) begin
            case (avs_address)
                `CFM_REG_CTRL: avs_readdata <= ctrl;
                `CFM_REG_STATUS: avs_readdata <= {26'h0, woke, changed, dev.osc_disable_bit,
                                                  dev.current_op_field};
                `CFM_REG_CFG: avs_readdata <= {24'h0, dev.cfg_rdata};
                `CFM_REG_COUNT: avs_readdata <= {8'h0, dev.bus_diag_reg1, dev.bus_diag_reg0,
                                                 dev.error_counter_reg};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // a switch between two normal or two debug modes goes by way of config
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl <= `CFM_CTRL_RESET;
            target <= `CFM_OP_CONFIG;
            target_pend <= 1'b0;
            dev.requested_op_field <= `CFM_OP_CONFIG;
            dev.req_stb <= 1'b0;
        end else if (ce) begin
            dev.req_stb <= 1'b0;
            if (wr && avs_address == `CFM_REG_CTRL) begin
                ctrl <= {24'h0, 2'b00, avs_writedata[5:0]};
                dev.req_stb <= 1'b1;
                target <= avs_writedata[2:0];
                target_pend <= conflict;
                dev.requested_op_field <= conflict ? `CFM_OP_CONFIG : avs_writedata[2:0];
            end else if (target_pend && dev.current_op_field == `CFM_OP_CONFIG && !dev.req_stb) begin
                target_pend <= 1'b0;
                dev.req_stb <= 1'b1;
                dev.requested_op_field <= target;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dev.osc_clear <= 1'b0;
            dev.cs_assert <= 1'b0;
            dev.cfg_stb <= 1'b0;
            dev.cfg_wdata <= 8'h00;
        end else if (ce) begin
            dev.osc_clear <= wr && avs_address == `CFM_REG_CTRL && avs_writedata[`CFM_CTRL_OSC_CLR];
            dev.cs_assert <= wr && avs_address == `CFM_REG_CTRL && avs_writedata[`CFM_CTRL_CS];
            dev.cfg_stb <= wr && avs_address == `CFM_REG_CFG;
            if (wr && avs_address == `CFM_REG_CFG)
                dev.cfg_wdata <= avs_writedata[7:0];
        end
    end

    always_comb begin
        dev.low_power_enable_bit = ctrl[`CFM_CTRL_LPM];
        dev.wake_irq_enable = ctrl[`CFM_CTRL_WAKE_IE];
        dev.wake_filter_enable = ctrl[`CFM_CTRL_WAKE_FILT];
    end

    // sticky flags: a new event wins over a write-one clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            changed <= 1'b0;
            woke <= 1'b0;
        end else if (ce) begin
            if (dev.op_change)
                changed <= 1'b1;
            else if (wr && avs_address == `CFM_REG_STATUS && avs_writedata[`CFM_STAT_CHANGED])
                changed <= 1'b0;
            if (dev.wake_irq)
                woke <= 1'b1;
            else if (wr && avs_address == `CFM_REG_STATUS && avs_writedata[`CFM_STAT_WAKE])
                woke <= 1'b0;
        end
    end
endmodule

// ---- core/cfm_if.sv ----
// link between the software-facing host end and the controller end
// assumes one clock shared by both ends
interface cfm_if;
    import cfm_pkg::*;
    cfm_op_t requested_op_field;
    logic req_stb;
    logic low_power_enable_bit;
    logic osc_clear;
    logic wake_irq_enable;
    logic wake_filter_enable;
    logic cfg_stb;
    logic [7:0] cfg_wdata;
    logic cs_assert;
    cfm_op_t current_op_field;
    logic osc_disable_bit;
    logic op_change;
    logic wake_irq;
    logic fifo_reset_flag;
    logic [7:0] cfg_rdata;
    logic [7:0] error_counter_reg;
    logic [7:0] bus_diag_reg0;
    logic [7:0] bus_diag_reg1;
    modport device (
        input requested_op_field, req_stb, low_power_enable_bit, osc_clear, wake_irq_enable,
        input wake_filter_enable, cfg_stb, cfg_wdata, cs_assert,
        output current_op_field, osc_disable_bit, op_change, wake_irq, fifo_reset_flag,
        output cfg_rdata, error_counter_reg, bus_diag_reg0, bus_diag_reg1
    );
    modport host (
        output requested_op_field, req_stb, low_power_enable_bit, osc_clear, wake_irq_enable,
        output wake_filter_enable, cfg_stb, cfg_wdata, cs_assert,
        input current_op_field, osc_disable_bit, op_change, wake_irq, fifo_reset_flag,
        input cfg_rdata, error_counter_reg, bus_diag_reg0, bus_diag_reg1
    );
endinterface

// ---- core/cfm_params.svh ----
// constants for the can fd mode controller: mode codes, register map, counts
// assumes inclusion by both ends and by the package
`ifndef CFM_PARAMS_SVH
`define CFM_PARAMS_SVH

`define CFM_OP_NORMAL_FD 3'h0
`define CFM_OP_SLEEP 3'h1
`define CFM_OP_LOOP_INT 3'h2
`define CFM_OP_LISTEN 3'h3
`define CFM_OP_CONFIG 3'h4
`define CFM_OP_LOOP_EXT 3'h5
`define CFM_OP_CLASSIC 3'h6
`define CFM_OP_RESTRICT 3'h7

`define CFM_INTEG_BITS 11
`define CFM_WAKE_FILT_CYC 16

`define CFM_REG_CTRL 4'h0
`define CFM_REG_STATUS 4'h4
`define CFM_REG_CFG 4'h8
`define CFM_REG_COUNT 4'hC

`define CFM_CTRL_LPM 3
`define CFM_CTRL_WAKE_IE 4
`define CFM_CTRL_WAKE_FILT 5
`define CFM_CTRL_OSC_CLR 6
`define CFM_CTRL_CS 7
`define CFM_STAT_OSC_DIS 3
`define CFM_STAT_CHANGED 4
`define CFM_STAT_WAKE 5

`define CFM_CTRL_RESET 32'h0000_0004

`endif

// ---- core/cfm_pkg.sv ----
// types shared by both ends of the mode controller
// assumes cfm_params.svh on the include path
`include "cfm_params.svh"
package cfm_pkg;
    typedef logic [2:0] cfm_op_t;
    typedef logic [3:0] cfm_dlc_t;
    typedef logic [6:0] cfm_bytes_t;
    typedef enum logic [4:0] {
        CFM_CFG = 5'b00001,
        CFM_INTEG = 5'b00010,
        CFM_RUN = 5'b00100,
        CFM_SLEEP = 5'b01000,
        CFM_LPM = 5'b10000
    } cfm_state_t;
endpackage

// ---- sim/can_fd_mode_control_tb.sv ----
// self-checking bench: host end and controller end joined by the mode link
// assumes the core files compiled first and a 100 MHz clock
module can_fd_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cfm_pkg::*;
    localparam logic [6:0] FD_LEN [16] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06,
        7'h07, 7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic bus_rx_pin = 1'b1, bit_tick = 1'b0, tx_bit = 1'b0, tx_busy = 1'b0, rx_busy = 1'b0;
    logic tx_err = 1'b0, rx_err = 1'b0, tx_fdf = 1'b1, tx_brs = 1'b1, tx_esi = 1'b1;
    logic rx_fdf = 1'b1, dlc_fd = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    cfm_dlc_t dlc = 4'h0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, bus_tx_pin, tx_fdf_out, tx_brs_out, tx_esi_out, rx_fd_error;
    logic crc21, clock_stop;
    cfm_bytes_t byte_count, exp_b;
    int bad_count = 0, checked = 0, cycles = 0;
    cfm_if link ();
    cfm_host cfm_host_i (.clk(clk), .reset(reset), .ce(ce), .dev(link),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    cfm_device #(.WAKE_FILT_CYC(4)) cfm_device_i (.clk(clk), .reset(reset), .ce(ce),
        .host(link), .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin), .bit_tick(bit_tick),
        .tx_bit(tx_bit), .tx_busy(tx_busy), .rx_busy(rx_busy), .tx_err(tx_err), .rx_err(rx_err),
        .tx_fdf(tx_fdf), .tx_brs(tx_brs), .tx_esi(tx_esi), .tx_fdf_out(tx_fdf_out),
        .tx_brs_out(tx_brs_out), .tx_esi_out(tx_esi_out), .rx_fdf(rx_fdf),
        .rx_fd_error(rx_fd_error), .dlc(dlc), .dlc_fd(dlc_fd), .byte_count(byte_count),
        .crc21(crc21), .clock_stop(clock_stop));
    cfm_link_sva cfm_link_sva_i (.clk(clk), .reset(reset),
        .current_op_field(link.current_op_field), .osc_disable_bit(link.osc_disable_bit),
        .op_change(link.op_change), .wake_irq(link.wake_irq),
        .wake_irq_enable(link.wake_irq_enable), .fifo_reset_flag(link.fifo_reset_flag),
        .cfg_stb(link.cfg_stb), .cfg_rdata(link.cfg_rdata),
        .error_counter_reg(link.error_counter_reg), .bus_diag_reg0(link.bus_diag_reg0),
        .bus_diag_reg1(link.bus_diag_reg1));
    initial forever #5 clk = ~clk;
    // a bit time of two cycles keeps integration short but still counted
    always @(posedge clk) bit_tick <= !bit_tick;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low; a hang ends at the cycle ceiling
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val);
        do bus(4'h4, 1'b0, 32'h0); while ((rd & mask) !== val);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            dlc <= i[3:0];
            dlc_fd <= i[4];
            repeat (2) @(posedge clk);
            exp_b = (!i[4] && i[3:0] > 4'h8) ? 7'h08 : FD_LEN[i[3:0]];
            chk(byte_count, exp_b);
            chk(crc21, i[4] && exp_b > 7'h10);
        end
        bus(4'h0, 1'b0, 32'h0);
        chk(rd, 32'h4);
        bus(4'h4, 1'b0, 32'h0);
        chk(rd[3:0], 4'h4);
        chk(link.fifo_reset_flag, 1'b1);
        bus(4'h2, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(4'h8, 1'b1, 32'h5A);
        bus(4'h8, 1'b0, 32'h0);
        chk(rd, 32'h5A);
        // bus stays recessive so only the busy flag can hold the request back
        tx_busy <= 1'b1;
        bus(4'h0, 1'b1, 32'h6);
        repeat (40) @(posedge clk);
        bus(4'h4, 1'b0, 32'h0);
        chk(rd[2:0], 3'h4);
        tx_busy <= 1'b0;
        bus_rx_pin <= 1'b0;
        repeat (40) @(posedge clk);
        bus(4'h4, 1'b0, 32'h0);
        chk(rd[2:0], 3'h4);
        bus_rx_pin <= 1'b1;
        wait_stat(32'h7, 32'h6);
        bus(4'h4, 1'b0, 32'h0);
        chk(rd[4], 1'b1);
        chk({tx_fdf_out, tx_brs_out, tx_esi_out}, 3'h0);
        chk(rx_fd_error, 1'b1);
        chk(bus_tx_pin, 1'b0);
        bus(4'h8, 1'b1, 32'h33);
        bus(4'h8, 1'b0, 32'h0);
        chk(rd, 32'h5A);
        tx_err <= 1'b1;
        rx_err <= 1'b1;
        @(posedge clk);
        tx_err <= 1'b0;
        rx_err <= 1'b0;
        bus(4'hC, 1'b0, 32'h0);
        chk(rd[23:8], 16'h0101);
        // errors offered while the enable is low must not be counted
        ce <= 1'b0;
        tx_err <= 1'b1;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        tx_err <= 1'b0;
        bus(4'hC, 1'b0, 32'h0);
        chk(rd[23:8], 16'h0101);
        tx_busy <= 1'b1;
        bus(4'h0, 1'b1, 32'h0);
        repeat (40) @(posedge clk);
        bus(4'h4, 1'b0, 32'h0);
        chk(rd[2:0], 3'h6);
        tx_busy <= 1'b0;
        wait_stat(32'h7, 32'h0);
        bus(4'hC, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({tx_fdf_out, tx_brs_out, tx_esi_out, rx_fd_error}, 4'hE);
        bus(4'h0, 1'b1, 32'h4);
        wait_stat(32'h7, 32'h4);
        bus(4'h0, 1'b1, 32'h3);
        wait_stat(32'h7, 32'h3);
        bus(4'h0, 1'b1, 32'h2);
        wait_stat(32'h7, 32'h2);
        bus(4'h0, 1'b1, 32'h1);
        repeat (20) @(posedge clk);
        bus(4'h4, 1'b0, 32'h0);
        chk(rd[3:0], 4'h2);
        bus(4'h0, 1'b1, 32'h4);
        wait_stat(32'h7, 32'h4);
        bus(4'h0, 1'b1, 32'h11);
        wait_stat(32'h8, 32'h8);
        chk(rd[2:0], 3'h4);
        chk({bus_tx_pin, clock_stop}, 2'h3);
        bus_rx_pin <= 1'b0;
        repeat (3) @(posedge clk);
        bus_rx_pin <= 1'b1;
        wait_stat(32'h8, 32'h0);
        chk(rd[5], 1'b1);
        chk(rd[2:0], 3'h4);
        bus(4'h0, 1'b1, 32'h11);
        wait_stat(32'h8, 32'h8);
        bus(4'h0, 1'b1, 32'h44);
        wait_stat(32'h8, 32'h0);
        chk(clock_stop, 1'b0);
        bus(4'h0, 1'b1, 32'h39);
        do @(posedge clk); while (clock_stop !== 1'b1);
        // a low shorter than the filter time must not wake
        bus_rx_pin <= 1'b0;
        repeat (2) @(posedge clk);
        bus_rx_pin <= 1'b1;
        repeat (6) @(posedge clk);
        chk(clock_stop, 1'b1);
        bus(4'h0, 1'b1, 32'h84);
        repeat (5) @(posedge clk);
        bus(4'h8, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(4'h4, 1'b0, 32'h0);
        chk({rd[3:0], clock_stop}, 5'h08);
        bus(4'h8, 1'b1, 32'hA5);
        bus(4'h8, 1'b0, 32'h0);
        chk(rd, 32'hA5);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus(4'h8, 1'b0, 32'h0);
        chk(rd, 32'h0);
        finish_test();
    end
endmodule

// ---- sim/cfm_link_sva.sv ----
// checker for the mode link between the host end and the controller end
// assumes one clock and a synchronous active-high reset shared by both ends
`include "cfm_params.svh"
module cfm_link_sva (
    input wire logic clk,
    input wire logic reset,
    input wire cfm_pkg::cfm_op_t current_op_field,
    input wire logic osc_disable_bit,
    input wire logic op_change,
    input wire logic wake_irq,
    input wire logic wake_irq_enable,
    input wire logic fifo_reset_flag,
    input wire logic cfg_stb,
    input wire logic [7:0] cfg_rdata,
    input wire logic [7:0] error_counter_reg,
    input wire logic [7:0] bus_diag_reg0,
    input wire logic [7:0] bus_diag_reg1
);
    import cfm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_field_move;
        $changed(current_op_field);
    endsequence
    sequence s_cfg_left;
        ($past(current_op_field) == `CFM_OP_CONFIG) && (current_op_field != `CFM_OP_CONFIG);
    endsequence
    a_reset_config: assert property ($fell(reset) |->
        current_op_field == `CFM_OP_CONFIG && fifo_reset_flag) else $error("not config after reset");
    // the flag follows the state on the same edge as the reported field
    // flag and field come from the same state, so the flag is never high while the field shows another mode than config
    a_flag_config: assert property (fifo_reset_flag |->
        current_op_field == `CFM_OP_CONFIG) else $error("fifo reset outside config");
    // the pulse is launched on the same edge that moves the field
    a_change_pulse: assert property (s_field_move |-> op_change)
        else $error("mode change without pulse");
    a_change_cause: assert property (op_change |->
        $changed(current_op_field)) else $error("spurious change pulse");
    a_sleep_shake: assert property ($rose(osc_disable_bit) |->
        current_op_field == `CFM_OP_CONFIG) else $error("sleep not reading config");
    a_sleep_exit: assert property ($fell(osc_disable_bit) |->
        current_op_field == `CFM_OP_CONFIG) else $error("sleep exit not to config");
    a_wake_gated: assert property (wake_irq |-> wake_irq_enable || $past(wake_irq_enable))
        else $error("wake interrupt while disabled");
    a_count_clear: assert property (s_cfg_left |-> error_counter_reg == 8'h00
        && bus_diag_reg0 == 8'h00 && bus_diag_reg1 == 8'h00) else $error("counters not cleared");
    a_cfg_guard: assert property (cfg_stb && current_op_field != `CFM_OP_CONFIG
        && !fifo_reset_flag |=> $stable(cfg_rdata)) else $error("setting written outside config");
endmodule
